// *** logic/iht_map.svh ***
/*
 * Register offsets, field positions, reset values and timing figures for the
 * sensor host port command timing block.
 * Assumes a 200 MHz core clock and a 32-bit APB register bus.
 */
`ifndef IHT_MAP_SVH
`define IHT_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define IHT_ADDR_GCMD 8'h00
`define IHT_ADDR_MSC 8'h04
`define IHT_ADDR_STATUS 8'h08
`define IHT_ADDR_TEMP 8'h0C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define IHT_GCMD_RESET_BIT 7
`define IHT_GCMD_CAL_BIT 1
`define IHT_GCMD_BACKUP_BIT 3
`define IHT_GCMD_FTEST_BIT 4
`define IHT_GCMD_STEST_BIT 2
`define IHT_MSC_MODE_HI 4
`define IHT_MSC_MODE_LO 2
`define IHT_STAT_VALID_BIT 0
`define IHT_STAT_BUSY_BIT 1
`define IHT_STAT_CMD_LO 4

// ----------------------------------------------------------------------------
// Mode codes and reset values
// ----------------------------------------------------------------------------
`define IHT_MODE_PULSE 3'h5
`define IHT_MODE_DIRECT 3'h1
`define IHT_MODE_RESET 3'h0

// ----------------------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------------------
`define IHT_CLK_MHZ 200
`define IHT_SAMPLE_HZ 2000
`define IHT_T_POWERUP_MS 252
`define IHT_T_RESET_MS 193
`define IHT_T_CAL_MS 142
`define IHT_T_BACKUP_MS 72
`define IHT_T_FTEST_MS 32
`define IHT_T_STEST_MS 14
`define IHT_T_SYNC_DR_US 256

`endif

// *** logic/iht_pkg.sv ***
/*
 * Types shared by the command timing block: command codes, bus carriers and
 * the packed state records of each module.
 * Assumes the constants of iht_map.svh are used alongside.
 */
package iht_pkg;

    // ------------------------------------------------------------------------
    // Command in progress
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_POWERUP,
        CMD_RESET,
        CMD_CALRESTORE,
        CMD_BACKUP,
        CMD_FLASHTEST,
        CMD_SELFTEST
    } iht_cmd_type;

    // ------------------------------------------------------------------------
    // APB carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } iht_apb_req_type;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } iht_apb_rsp_type;

    // ------------------------------------------------------------------------
    // Module state records
    // ------------------------------------------------------------------------
    typedef struct packed {
        iht_apb_rsp_type rsp;
        logic [2:0] sync_mode;
        iht_cmd_type cmd;
        logic [25:0] timer;
        logic [5:0] st_ticks;
        logic [25:0] sample_cnt;
        logic tgl_meta;
        logic tgl_sync;
        logic tgl_last;
        logic rst_meta;
        logic rst_sync;
        logic [25:0] dr_cnt;
        logic dr_pending;
        logic data_ready;
        logic data_valid;
        logic [15:0] temp;
    } iht_core_state_type;

    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        logic toggle;
    } iht_edge_state_type;

endpackage : iht_pkg

// *** logic/iht_sync_edge.sv ***
/*
 * Sync pin clock domain: turns each rising edge of the external sync clock,
 * after the first two that follow reset, into a change of a toggle level for
 * the core clock domain to pick up.
 * Assumes the sync clock may stop between pulses; rst_n comes from the core.
 */
`timescale 1ns/1ps
module iht_sync_edge (
    // External sync clock
    input wire logic sync_clk,
    // Core reset, active low
    input wire logic rst_n,
    // Edge event as toggle level
    output logic sync_toggle
);

    iht_pkg::iht_edge_state_type s;
    iht_pkg::iht_edge_state_type next_s;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // The toggle holds still until the released reset has crossed over.
    always_comb begin
        next_s = s;
        next_s.rst_meta = 1'b1;
        next_s.rst_sync = s.rst_meta;
        next_s.toggle = s.rst_sync ? ~s.toggle : 1'b0;
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // The sync clock may stand still during reset, so reset acts without it.
    always_ff @(posedge sync_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sync_toggle = s.toggle;

endmodule : iht_sync_edge

// *** logic/iht_core.sv ***
/*
 * Command timing core: APB registers, global command sequencing with
 * recovery timers, sample clock selection and data ready generation.
 * Assumes an APB master on mclk and a sync clock unrelated to mclk.
 */
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "iht_map.svh"
module iht_core #(
    parameter int POWERUP_CYC = `IHT_T_POWERUP_MS * 1000 * `IHT_CLK_MHZ,
    parameter int RESET_CYC = `IHT_T_RESET_MS * 1000 * `IHT_CLK_MHZ,
    parameter int CAL_CYC = `IHT_T_CAL_MS * 1000 * `IHT_CLK_MHZ,
    parameter int BACKUP_CYC = `IHT_T_BACKUP_MS * 1000 * `IHT_CLK_MHZ,
    parameter int FTEST_CYC = `IHT_T_FTEST_MS * 1000 * `IHT_CLK_MHZ,
    parameter int SYNC_DR_CYC = `IHT_T_SYNC_DR_US * `IHT_CLK_MHZ,
    parameter int SAMPLE_CYC = `IHT_CLK_MHZ * 1000000 / `IHT_SAMPLE_HZ
) (
    // Core clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire iht_pkg::iht_apb_req_type apb_req,
    output iht_pkg::iht_apb_rsp_type apb_rsp,
    // Device pins
    input wire logic sync_clk,
    input wire logic ext_rst_n,
    output logic data_ready,
    output logic data_valid,
    // Temperature from the sensor path, same clock
    input wire logic [15:0] temp_in
);

    localparam int ST_SAMPLES = `IHT_T_STEST_MS * `IHT_SAMPLE_HZ / 1000;

    iht_pkg::iht_core_state_type s;
    iht_pkg::iht_core_state_type next_s;

    logic sync_toggle;
    logic sync_evt;
    logic ext_mode;
    logic int_tick;
    logic tick;
    logic busy;
    logic apb_wr;
    logic dr_fire;
    logic cmd_ok;

    // ------------------------------------------------------------------------
    // Sync clock domain
    // ------------------------------------------------------------------------
    iht_sync_edge u_edge (
        .sync_clk(sync_clk),
        .rst_n(rst_n),
        .sync_toggle(sync_toggle)
    );

    // ------------------------------------------------------------------------
    // Decoded conditions
    // ------------------------------------------------------------------------
    // Only the second and third crossing stages are compared.
    assign sync_evt = s.tgl_sync ^ s.tgl_last;
    assign ext_mode = (s.sync_mode == `IHT_MODE_PULSE) || (s.sync_mode == `IHT_MODE_DIRECT);
    assign int_tick = (s.sample_cnt == 26'h0000000);
    assign tick = ext_mode ? sync_evt : int_tick;
    assign busy = (s.cmd != iht_pkg::CMD_NONE);
    assign apb_wr = apb_req.psel && apb_req.penable && s.rsp.pready && apb_req.pwrite;
    assign dr_fire = ext_mode ? (s.dr_pending && s.dr_cnt == 26'h0000000) : int_tick;
    assign cmd_ok = !busy && !apb_req.pwdata[`IHT_GCMD_RESET_BIT] && s.rst_sync;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.rsp.pready = 1'b0;
        next_s.data_ready = 1'b0;

        // Two-stage crossings for the sync toggle and the reset pin.
        next_s.tgl_meta = sync_toggle;
        next_s.tgl_sync = s.tgl_meta;
        next_s.tgl_last = s.tgl_sync;
        next_s.rst_meta = ext_rst_n;
        next_s.rst_sync = s.rst_meta;

        // Internal sample clock runs always, so switching modes needs no restart.
        if (int_tick) begin
            next_s.sample_cnt = 26'(SAMPLE_CYC - 1);
        end else begin
            next_s.sample_cnt = s.sample_cnt - 26'h0000001;
        end

        // A sync edge restarts the delay; a second edge inside it wins.
        if (ext_mode && sync_evt) begin
            next_s.dr_pending = 1'b1;
            next_s.dr_cnt = 26'(SYNC_DR_CYC - 1);
        end else if (s.dr_pending) begin
            if (s.dr_cnt == 26'h0000000) begin
                next_s.dr_pending = 1'b0;
            end else begin
                next_s.dr_cnt = s.dr_cnt - 26'h0000001;
            end
        end
        if (dr_fire && !busy) begin
            next_s.data_ready = 1'b1;
        end

        // Temperature is kept in raw counts of a tenth of a degree.
        if (tick) begin
            next_s.temp = temp_in;
        end

        // Recovery timers; self test counts samples so slow sync stretches it.
        if (busy) begin
            if (s.cmd == iht_pkg::CMD_SELFTEST) begin
                if (tick) begin
                    if (s.st_ticks <= 6'h01) begin
                        next_s.cmd = iht_pkg::CMD_NONE;
                        next_s.data_valid = 1'b1;
                    end else begin
                        next_s.st_ticks = s.st_ticks - 6'h01;
                    end
                end
            end else if (s.timer == 26'h0000000) begin
                next_s.cmd = iht_pkg::CMD_NONE;
                next_s.data_valid = 1'b1;
            end else begin
                next_s.timer = s.timer - 26'h0000001;
            end
        end

        // APB setup phase: answer is prepared for the first access cycle.
        if (apb_req.psel && !apb_req.penable) begin
            next_s.rsp.pready = 1'b1;
            next_s.rsp.pslverr = 1'b0;
            next_s.rsp.prdata = 32'h00000000;
            case (apb_req.paddr)
                `IHT_ADDR_GCMD: begin
                    next_s.rsp.prdata = 32'h00000000;
                end
                `IHT_ADDR_MSC: begin
                    next_s.rsp.prdata[`IHT_MSC_MODE_HI:`IHT_MSC_MODE_LO] = s.sync_mode;
                end
                `IHT_ADDR_STATUS: begin
                    next_s.rsp.prdata[`IHT_STAT_VALID_BIT] = s.data_valid;
                    next_s.rsp.prdata[`IHT_STAT_BUSY_BIT] = busy;
                    next_s.rsp.prdata[`IHT_STAT_CMD_LO +: 3] = s.cmd;
                end
                `IHT_ADDR_TEMP: begin
                    next_s.rsp.prdata[15:0] = s.temp;
                end
                default: begin
                    next_s.rsp.pslverr = 1'b1;
                end
            endcase
        end

        // APB write, taken only in the completing access cycle.
        if (apb_wr) begin
            if (apb_req.paddr == `IHT_ADDR_MSC) begin
                next_s.sync_mode = apb_req.pwdata[`IHT_MSC_MODE_HI:`IHT_MSC_MODE_LO];
            end else if (apb_req.paddr == `IHT_ADDR_GCMD) begin
                // Reset is always taken; other commands are dropped while busy.
                if (apb_req.pwdata[`IHT_GCMD_RESET_BIT]) begin
                    next_s.cmd = iht_pkg::CMD_RESET;
                    next_s.timer = 26'(RESET_CYC - 1);
                    next_s.data_valid = 1'b0;
                end else if (!busy) begin
                    if (apb_req.pwdata[`IHT_GCMD_CAL_BIT]) begin
                        next_s.cmd = iht_pkg::CMD_CALRESTORE;
                        next_s.timer = 26'(CAL_CYC - 1);
                        next_s.data_valid = 1'b0;
                    end else if (apb_req.pwdata[`IHT_GCMD_BACKUP_BIT]) begin
                        next_s.cmd = iht_pkg::CMD_BACKUP;
                        next_s.timer = 26'(BACKUP_CYC - 1);
                        next_s.data_valid = 1'b0;
                    end else if (apb_req.pwdata[`IHT_GCMD_FTEST_BIT]) begin
                        next_s.cmd = iht_pkg::CMD_FLASHTEST;
                        next_s.timer = 26'(FTEST_CYC - 1);
                        next_s.data_valid = 1'b0;
                    end else if (apb_req.pwdata[`IHT_GCMD_STEST_BIT]) begin
                        next_s.cmd = iht_pkg::CMD_SELFTEST;
                        next_s.st_ticks = 6'(ST_SAMPLES);
                        next_s.data_valid = 1'b0;
                    end
                end
            end
        end

        // Reset pin low keeps reloading the recovery; its width is the host's.
        if (!s.rst_sync) begin
            next_s.cmd = iht_pkg::CMD_RESET;
            next_s.timer = 26'(RESET_CYC - 1);
            next_s.data_valid = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Power-up counts as a command so the same busy path guards it.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= '0;
            s.cmd <= iht_pkg::CMD_POWERUP;
            s.timer <= 26'(POWERUP_CYC - 1);
            s.sync_mode <= `IHT_MODE_RESET;
            s.rst_meta <= 1'b1;
            s.rst_sync <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign apb_rsp = s.rsp;
    assign data_ready = s.data_ready;
    assign data_valid = s.data_valid;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_cmd_write(int b);
        apb_wr && apb_req.paddr == `IHT_ADDR_GCMD && apb_req.pwdata[b];
    endsequence

    sequence s_sync_seen;
        ext_mode && sync_evt;
    endsequence

    sequence s_delay_done;
        s.dr_pending && s.dr_cnt == 26'h0000000 && !busy && !sync_evt;
    endsequence

    property p_powerup;
        $rose(rst_n) |-> s.cmd == iht_pkg::CMD_POWERUP && !s.data_valid
            && s.timer == 26'(POWERUP_CYC - 1);
    endproperty
    a_powerup: assert property (p_powerup) else $error("power-up wait not armed");

    property p_reset_cmd;
        s_cmd_write(7) |=> s.cmd == iht_pkg::CMD_RESET && s.timer == 26'(RESET_CYC - 1);
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("reset command not started");

    property p_cal_cmd;
        s_cmd_write(1) ##0 cmd_ok |=> s.cmd == iht_pkg::CMD_CALRESTORE
            && s.timer == 26'(CAL_CYC - 1) && !s.data_valid;
    endproperty
    a_cal_cmd: assert property (p_cal_cmd) else $error("calibration restore not started");

    property p_backup_cmd;
        s_cmd_write(3) ##0 (cmd_ok && !apb_req.pwdata[1]) |=>
            s.cmd == iht_pkg::CMD_BACKUP && s.timer == 26'(BACKUP_CYC - 1);
    endproperty
    a_backup_cmd: assert property (p_backup_cmd) else $error("flash backup not started");

    property p_ftest_cmd;
        s_cmd_write(4) ##0 (cmd_ok && !apb_req.pwdata[1] && !apb_req.pwdata[3]) |=>
            s.cmd == iht_pkg::CMD_FLASHTEST && s.timer == 26'(FTEST_CYC - 1);
    endproperty
    a_ftest_cmd: assert property (p_ftest_cmd) else $error("flash test not started");

    property p_stest_cmd;
        s_cmd_write(2) ##0 (cmd_ok && apb_req.pwdata[4:3] == 2'h0 && !apb_req.pwdata[1])
            |=> s.cmd == iht_pkg::CMD_SELFTEST && s.st_ticks == 6'(ST_SAMPLES);
    endproperty
    a_stest_cmd: assert property (p_stest_cmd) else $error("self test not started");

    property p_stest_pace;
        s.cmd == iht_pkg::CMD_SELFTEST && !tick && s.rst_sync && !apb_wr
            |=> $stable(s.st_ticks) && s.cmd == iht_pkg::CMD_SELFTEST;
    endproperty
    a_stest_pace: assert property (p_stest_pace) else $error("self test ran without sample");

    property p_sync_arm;
        s_sync_seen |=> s.dr_pending && s.dr_cnt == 26'(SYNC_DR_CYC - 1);
    endproperty
    a_sync_arm: assert property (p_sync_arm) else $error("sync delay not armed");

    property p_sync_fire;
        ext_mode ##0 s_delay_done |=> s.data_ready ##1 !s.data_ready;
    endproperty
    a_sync_fire: assert property (p_sync_fire) else $error("data ready missed after delay");

    property p_busy_quiet;
        busy |=> !s.data_ready;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("data ready while busy");

    property p_mode_write;
        apb_wr && apb_req.paddr == `IHT_ADDR_MSC |=> s.sync_mode == $past(apb_req.pwdata[4:2]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("sync mode not stored");

    property p_temp_take;
        tick |=> s.temp == $past(temp_in);
    endproperty
    a_temp_take: assert property (p_temp_take) else $error("temperature not captured");

endmodule : iht_core

// *** testbench/iht_host_model.sv ***
/*
 * Host-side model: drives the sync clock in short frames and the reset pin.
 * Assumes the bench calls its tasks; the sync clock idles low between frames.
 */
`timescale 1ns/1ps
module iht_host_model (
    // Pins toward the device
    output logic sync_clk,
    output logic ext_rst_n
);
    // ------------------------------------------------------------------------
    // Idle pin levels
    // ------------------------------------------------------------------------
    initial begin
        sync_clk = 1'b0;
        ext_rst_n = 1'b1;
    end

    // Sends n rising edges, each held high for 24 ns, with gap_ns of silence after each.
    // The offset keeps the edges out of phase with the core clock.
    task automatic sync_pulses(input int n, input int gap_ns);
        #7;
        repeat (n) begin
            sync_clk = 1'b1;
            #24;
            sync_clk = 1'b0;
            #(gap_ns);
        end
    endtask : sync_pulses

    // Holds the reset pin low; the width is scaled down but spans many cycles.
    // Non-blocking, so a call right after a core edge never races that edge.
    task automatic pin_reset(input int ns);
        ext_rst_n <= 1'b0;
        #(ns);
        ext_rst_n <= 1'b1;
    endtask : pin_reset
endmodule : iht_host_model

// *** testbench/tb.sv ***
/*
 * Self-checking bench for the command timing core with shortened counts.
 * Assumes the register map header and a host model for the sync and reset pins.
 */
`timescale 1ns/1ps
`include "iht_map.svh"
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
    $display("ERROR %s expected %0h seen %0h", nm, (exp), (got)); end end
module tb;
    localparam int PWR = 200;
    localparam int RST = 150;
    localparam int SDR = 60;
    localparam int SMP = 40;
    // Scaled stall between host words, in core cycles.
    localparam int GAP = 3;
    // Clock, reset and bus
    logic mclk;
    logic rst_n;
    iht_pkg::iht_apb_req_type req;
    iht_pkg::iht_apb_rsp_type rsp;
    // Device pins
    logic sync_clk;
    logic ext_rst_n;
    logic data_ready;
    logic data_valid;
    logic [15:0] temp_in;
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    int rel;
    logic [31:0] rd;
    logic err;

    iht_core #(.POWERUP_CYC(PWR), .RESET_CYC(RST), .CAL_CYC(120), .BACKUP_CYC(100),
        .FTEST_CYC(80), .SYNC_DR_CYC(SDR), .SAMPLE_CYC(SMP)) dut_u (.mclk(mclk),
        .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp), .sync_clk(sync_clk),
        .ext_rst_n(ext_rst_n), .data_ready(data_ready), .data_valid(data_valid),
        .temp_in(temp_in));
    iht_host_model host_u (.sync_clk(sync_clk), .ext_rst_n(ext_rst_n));

    // ------------------------------------------------------------------------
    // Clock and cycle count
    // ------------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
    end

    task automatic stop_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    function automatic logic inr(input int v, input int lo, input int hi);
        return (v >= lo && v <= hi);
    endfunction : inr

    // One APB transfer; it opens with an edge so back-to-back calls never
    // assign psel twice in one time step.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        repeat (GAP) @(posedge mclk);
        req.psel <= 1'b1;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) begin
            fails++;
            $display("ERROR pready expected 1 seen 0");
            stop_test();
        end else begin
            rd = rsp.prdata;
            err = rsp.pslverr;
            req.psel <= 1'b0;
            req.penable <= 1'b0;
        end
    endtask : apb

    // Waits for data_ready (rdy set) or data_valid; a timeout ends the run.
    task automatic wait_sig(input bit rdy, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while ((rdy ? data_ready : data_valid) !== 1'b1 && n < lim);
        if ((rdy ? data_ready : data_valid) !== 1'b1) begin
            fails++;
            $display("ERROR wait expected 1 seen 0");
            stop_test();
        end
    endtask : wait_sig

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_power;
        apb(1'b0, `IHT_ADDR_MSC, 32'h0);
        `CHK("msc_reset", 32'h0, rd)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped_err", 1'b1, err)
        `CHK("unmapped_data", 32'h0, rd)
        apb(1'b0, `IHT_ADDR_STATUS, 32'h0);
        `CHK("powerup_status", 32'h12, rd)
        wait_sig(1'b0, PWR + 20);
        `CHK("powerup_time", 1'b1, inr(cyc - rel, PWR - 2, PWR + 6))
        $display("test powerup done");
    endtask : t_power

    task automatic t_cmds;
        int bits[5] = '{7, 1, 3, 4, 2};
        int dur[5] = '{RST, 120, 100, 80, 28 * SMP};
        int t0;
        int tol;
        for (int i = 0; i < 5; i++) begin
            tol = (i == 4) ? SMP : 2;
            apb(1'b1, `IHT_ADDR_GCMD, 32'h1 << bits[i]);
            t0 = cyc;
            apb(1'b0, `IHT_ADDR_STATUS, 32'h0);
            `CHK("cmd_status", {25'h0, 3'(i + 2), 4'h2}, rd)
            apb(1'b0, `IHT_ADDR_GCMD, 32'h0);
            `CHK("gcmd_read", 32'h0, rd)
            if (i == 2) begin
                // A second command while busy must not displace the running one.
                apb(1'b1, `IHT_ADDR_GCMD, 32'h2);
                apb(1'b0, `IHT_ADDR_STATUS, 32'h0);
                `CHK("busy_drop", 32'h42, rd)
            end
            wait_sig(1'b0, dur[i] + tol + 20);
            `CHK("cmd_time", 1'b1, inr(cyc - t0, dur[i] - tol, dur[i] + tol + 4))
        end
        $display("test commands done");
    endtask : t_cmds

    task automatic t_stretch;
        // The sync side needs two edges to leave reset; they must not count as ticks.
        host_u.sync_pulses(2, 24);
        apb(1'b1, `IHT_ADDR_MSC, 32'h4);
        apb(1'b1, `IHT_ADDR_GCMD, 32'h4);
        repeat (29 * SMP) @(posedge mclk);
        `CHK("stretch_idle", 1'b0, data_valid)
        host_u.sync_pulses(26, 24);
        @(posedge mclk);
        `CHK("stretch_26", 1'b0, data_valid)
        host_u.sync_pulses(3, 24);
        wait_sig(1'b0, 100);
        `CHK("stretch_done", 1'b1, data_valid)
        $display("test stretch done");
    endtask : t_stretch

    task automatic t_sync;
        logic [31:0] m[2] = '{32'h14, 32'h4};
        int t0;
        repeat (100) @(posedge mclk);
        foreach (m[i]) begin
            apb(1'b1, `IHT_ADDR_MSC, m[i]);
            apb(1'b0, `IHT_ADDR_MSC, 32'h0);
            `CHK("msc_mode", m[i], rd)
            @(posedge mclk);
            t0 = cyc;
            host_u.sync_pulses(1, 0);
            wait_sig(1'b1, SDR + 40);
            `CHK("sync_delay", 1'b1, inr(cyc - t0, SDR + 2, SDR + 9))
            @(posedge mclk);
            `CHK("dr_width", 1'b0, data_ready)
        end
        $display("test sync done");
    endtask : t_sync

    task automatic t_internal;
        logic [15:0] v[2] = '{16'h0000, 16'h01F4};
        int t0;
        apb(1'b1, `IHT_ADDR_MSC, 32'h0);
        wait_sig(1'b1, SMP + 10);
        t0 = cyc;
        wait_sig(1'b1, SMP + 10);
        `CHK("tick_period", SMP, cyc - t0)
        foreach (v[i]) begin
            temp_in <= v[i];
            repeat (SMP + 5) @(posedge mclk);
            apb(1'b0, `IHT_ADDR_TEMP, 32'h0);
            `CHK("temperature", {16'h0, v[i]}, rd)
        end
        $display("test internal done");
    endtask : t_internal

    task automatic t_pin;
        int t0;
        @(posedge mclk);
        host_u.pin_reset(100);
        t0 = cyc;
        apb(1'b0, `IHT_ADDR_STATUS, 32'h0);
        `CHK("pin_status", 32'h22, rd)
        wait_sig(1'b0, RST + 30);
        `CHK("pin_time", 1'b1, inr(cyc - t0, RST - 2, RST + 6))
        $display("test pin reset done");
    endtask : t_pin

    // ------------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        req = '0;
        temp_in = 16'h0123;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        rel = cyc;
        t_power();
        t_cmds();
        t_stretch();
        t_sync();
        t_internal();
        t_pin();
        stop_test();
    end
    initial begin
        #100000;
        fails++;
        $display("ERROR watchdog expected done seen hang");
        stop_test();
    end
endmodule : tb
